// ### hdl/asp_playback.sv
/*
  asp_playback: segment playback engine of an arbitrary waveform generator,
  with segment table, switch control and an Avalon-MM register slave.
  Assumes a working memory outside that answers in the fetch cycle itself, and that
  CLK_EN_IN high marks one sample clock cycle.
*/
// Design decisions made here: the register offsets and the Avalon-MM register port.
// What this block does
// [RQ1] each sample cycle fetches one stored point and sends it out, in order
// [RQ2] samples are 12 bits wide whatever the amplitude
// [RQ3] memory holds 32,000,000 points, 64,000,000 with the larger option
// [RQ4] segment lengths below 384 or not a multiple of 32 are refused
// [RQ5] the table divides memory into up to 32k segments
// [RQ6] only the active segment is played
// [RQ7] any segment number is accepted; an empty one produces no output
// [RQ8] switch source is remote command or external port; remote after reset
// [RQ9] external source with nothing driven plays the first segment
// [RQ10] coherent mode switches only after the final sample of the segment
// [RQ11] immediate mode abandons the current segment at once
// [RQ12] switch timing is coherent after reset
// [RQ13] delete-all clears only the table, never the sample memory
// [RQ14] rewriting the same table after a delete restores the waveforms
// [RQ15] enabling arbitrary output starts the active segment with no start action
// [RQ16] external 8-bit segment number takes effect only on its valid strobe
// [RQ17] playback wraps from stop back to start while nothing is pending
`timescale 1ns/1ps
`default_nettype none
`include "asp_defines.svh"

module asp_playback
  import asp_pkg::*;
#(
  parameter int MEM_DEPTH = `ASP_MEM_DEPTH_BASE, // [RQ3]
  parameter int AW = `ASP_ADDR_W,
  parameter int SEG_COUNT = `ASP_SEG_COUNT
) (
  input wire logic CLK_IN,
  input wire logic RESET_N_IN,
  input wire logic CLK_EN_IN,
  input wire logic [`ASP_BUS_AW-1:0] AVS_ADDRESS_IN,
  input wire logic AVS_READ_IN,
  input wire logic AVS_WRITE_IN,
  input wire logic [31:0] AVS_WRITEDATA_IN,
  input wire logic [3:0] AVS_BYTEENABLE_IN,
  output logic [31:0] AVS_READDATA_OUT,
  output logic AVS_WAITREQUEST_OUT,
  input wire logic [`ASP_EXT_W-1:0] EXT_SEG_IN,
  input wire logic EXT_VALID_IN,
  output logic [AW-1:0] MEM_ADDR_OUT,
  output logic MEM_RD_OUT,
  input wire logic [`ASP_SAMPLE_W-1:0] MEM_DATA_IN,
  output logic [`ASP_SAMPLE_W-1:0] DAC_DATA_OUT,
  output logic DAC_VALID_OUT
);

  localparam int SW = $clog2(SEG_COUNT);
  localparam int DW = `ASP_SAMPLE_W;
  localparam logic [AW:0] DEPTH_L = (AW+1)'(MEM_DEPTH);
  localparam logic [AW-1:0] MIN_LEN = AW'(`ASP_MIN_SEG_LEN);
  localparam logic [AW-1:0] GRAN = AW'(`ASP_SEG_GRAN);

  if (MEM_DEPTH > `ASP_MEM_DEPTH_OPT || MEM_DEPTH < `ASP_MIN_SEG_LEN
      || (64'(1) << AW) < 64'(MEM_DEPTH)) begin : g_bad_depth
    $error("asp_playback: MEM_DEPTH does not fit AW or the allowed range");
  end
  if (SEG_COUNT > `ASP_SEG_COUNT || SEG_COUNT < (1 << `ASP_EXT_W)
      || SW > `ASP_ST_SEG_LSB - 1) begin : g_bad_segs
    $error("asp_playback: SEG_COUNT must lie between 256 and 32768");
  end

  function automatic logic [31:0] be_merge(input logic [31:0] old_v,
                                           input logic [31:0] new_v,
                                           input logic [3:0] be);
    logic [31:0] r;
    r = old_v;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        r[8*b +: 8] = new_v[8*b +: 8];
      end
    end
    return r;
  endfunction : be_merge

  // length and placement check for one table entry
  function automatic logic entry_ok(input logic [AW-1:0] start,
                                    input logic [AW-1:0] len);
    logic [AW:0] top;
    top = {1'b0, start} + {1'b0, len};
    return (len >= MIN_LEN) && ((len % GRAN) == '0) && (top <= DEPTH_L);
  endfunction : entry_ok

  // external select pins
  logic [`ASP_EXT_W:0] ext_s;
  asp_sync3 #(.W(`ASP_EXT_W + 1)) u_ext_sync (
    .clk_in(CLK_IN),
    .reset_n_in(RESET_N_IN),
    .ce_in(CLK_EN_IN),
    .pin_in({EXT_VALID_IN, EXT_SEG_IN}),
    .stable_out(ext_s)
  );

  // bus slave state
  logic wait_q, wait_d;
  logic [31:0] rdata_q, rdata_d;
  logic [`ASP_CTRL_W-1:0] ctrl_q, ctrl_d;
  logic [SW-1:0] active_q, active_d;
  logic [SW-1:0] tidx_q, tidx_d;
  logic [AW-1:0] tstart_q, tstart_d;
  logic rej_q, rej_d;
  logic del_w, commit_w;
  logic [AW-1:0] tlen_w;

  // table storage
  logic [AW-1:0] first_mem [SEG_COUNT];
  logic [AW-1:0] last_mem [SEG_COUNT];
  logic [SEG_COUNT-1:0] valid_q, valid_d;

  // playback state
  asp_state_type st_q, st_d;
  logic [SW-1:0] seg_q, seg_d;
  logic [AW-1:0] addr_q, addr_d, first_q, first_d, last_q, last_d;
  logic [`ASP_EXT_W-1:0] ext_sel_q, ext_sel_d;
  logic ext_vld_prev_q;
  logic rd_q, rd_d;
  logic [AW-1:0] maddr_q, maddr_d;
  logic [DW-1:0] dac_q, dac_d;
  logic dac_vld_q, dac_vld_d;
  logic [SW-1:0] req_seg;
  logic load;

  logic acc, wr_acc;
  logic [31:0] wv;
  logic [31:0] cur_v;

  assign acc = (AVS_READ_IN || AVS_WRITE_IN) && !wait_q;
  assign wr_acc = acc && AVS_WRITE_IN;

  always_comb begin
    case (AVS_ADDRESS_IN)
      `ASP_OFS_CTRL: cur_v = 32'(ctrl_q);
      `ASP_OFS_ACTIVE: cur_v = 32'(active_q);
      `ASP_OFS_TIDX: cur_v = 32'(tidx_q);
      `ASP_OFS_TSTART: cur_v = 32'(tstart_q);
      default: cur_v = 32'h0;
    endcase
    wv = be_merge(cur_v, AVS_WRITEDATA_IN, AVS_BYTEENABLE_IN);
  end

  always_comb begin
    wait_d = !((AVS_READ_IN || AVS_WRITE_IN) && wait_q);
    rdata_d = rdata_q;
    ctrl_d = ctrl_q;
    active_d = active_q;
    tidx_d = tidx_q;
    tstart_d = tstart_q;
    rej_d = rej_q;
    del_w = 1'b0;
    commit_w = 1'b0;
    tlen_w = AW'(wv);
    if (AVS_READ_IN && wait_q) begin
      case (AVS_ADDRESS_IN)
        `ASP_OFS_CTRL, `ASP_OFS_ACTIVE, `ASP_OFS_TIDX, `ASP_OFS_TSTART: begin
          rdata_d = cur_v;
        end
        `ASP_OFS_STATUS: begin
          rdata_d = 32'h0;
          rdata_d[`ASP_ST_PLAY] = (st_q == ASP_RUN);
          rdata_d[`ASP_ST_EMPTY] = (st_q == ASP_EMPTY);
          rdata_d[`ASP_ST_REJ] = rej_q;
          rdata_d[`ASP_ST_PEND] = (req_seg != seg_q);
          rdata_d[`ASP_ST_SEG_LSB +: SW] = seg_q;
        end
        `ASP_OFS_ADDR: rdata_d = 32'(addr_q);
        default: rdata_d = 32'h0;
      endcase
    end
    if (wr_acc) begin
      case (AVS_ADDRESS_IN)
        `ASP_OFS_CTRL: begin
          ctrl_d = wv[`ASP_CTRL_W-1:0];
          del_w = wv[`ASP_CTRL_DEL]; // [RQ13]
        end
        `ASP_OFS_ACTIVE: active_d = SW'(wv); // [RQ7]
        `ASP_OFS_TIDX: tidx_d = SW'(wv);
        `ASP_OFS_TSTART: tstart_d = AW'(wv);
        `ASP_OFS_TLEN: commit_w = 1'b1;
        `ASP_OFS_STATUS: begin
          if (AVS_BYTEENABLE_IN[0] && AVS_WRITEDATA_IN[`ASP_ST_REJ]) begin
            rej_d = 1'b0;
          end
        end
        default: ;
      endcase
    end
    // bad length refused; the refusal sets the sticky flag over a clear
    if (commit_w && !entry_ok(tstart_q, tlen_w)) begin
      rej_d = 1'b1; // [RQ4]
    end
  end

  // table: delete drops only the valid bits, sample memory is outside and
  // untouched, so a rewrite of the same entries brings the waveforms back
  always_comb begin
    valid_d = valid_q;
    if (del_w) begin
      valid_d = '0; // [RQ13]
    end else if (commit_w && entry_ok(tstart_q, tlen_w)) begin
      valid_d[tidx_q] = 1'b1; // [RQ4] [RQ5] [RQ14]
    end
  end

  always_ff @(posedge CLK_IN) begin
    if (CLK_EN_IN && commit_w && !del_w && entry_ok(tstart_q, tlen_w)) begin
      first_mem[tidx_q] <= tstart_q;
      last_mem[tidx_q] <= AW'(tstart_q + tlen_w - AW'(1));
    end
  end

  // external selection: first segment until a strobe arrives
  always_comb begin
    ext_sel_d = ext_sel_q;
    if (!ctrl_q[`ASP_CTRL_SRC]) begin
      ext_sel_d = '0; // [RQ9]
    end else if (ext_s[`ASP_EXT_W] && !ext_vld_prev_q) begin
      ext_sel_d = ext_s[`ASP_EXT_W-1:0]; // [RQ16]
    end
  end

  assign req_seg = ctrl_q[`ASP_CTRL_SRC] ? SW'(ext_sel_q) : active_q; // [RQ8]

  always_comb begin
    st_d = st_q;
    seg_d = seg_q;
    addr_d = addr_q;
    first_d = first_q;
    last_d = last_q;
    rd_d = 1'b0;
    maddr_d = maddr_q;
    load = 1'b0;
    if (!ctrl_q[`ASP_CTRL_EN] || del_w) begin
      st_d = ASP_IDLE;
    end else begin
      case (st_q)
        ASP_IDLE: load = 1'b1; // [RQ15]
        ASP_RUN: begin
          rd_d = 1'b1; // [RQ1] [RQ6]
          maddr_d = addr_q;
          if (req_seg != seg_q
              && (ctrl_q[`ASP_CTRL_IMM] || addr_q == last_q)) begin
            load = 1'b1; // [RQ10] [RQ11]
          end else if (addr_q == last_q) begin
            addr_d = first_q; // [RQ17]
          end else begin
            addr_d = addr_q + AW'(1);
          end
        end
        ASP_EMPTY: begin
          // picks up a segment as soon as its entry is written
          load = (req_seg != seg_q) || valid_q[seg_q]; // [RQ7] [RQ14]
        end
        default: st_d = ASP_IDLE;
      endcase
    end
    if (load) begin
      seg_d = req_seg;
      if (valid_q[req_seg]) begin
        st_d = ASP_RUN;
        addr_d = first_mem[req_seg];
        first_d = first_mem[req_seg];
        last_d = last_mem[req_seg];
      end else begin
        st_d = ASP_EMPTY; // [RQ7]
      end
    end
  end

  // memory word taken in the fetch cycle itself, then the converter register
  always_comb begin
    dac_d = dac_q;
    dac_vld_d = rd_q;
    if (rd_q) begin
      dac_d = MEM_DATA_IN; // [RQ1] [RQ2]
    end
  end

  always_ff @(posedge CLK_IN) begin
    if (!RESET_N_IN) begin
      wait_q <= 1'b1;
      rdata_q <= 32'h0;
      ctrl_q <= `ASP_CTRL_RST; // [RQ8] [RQ12]
      active_q <= '0;
      tidx_q <= '0;
      tstart_q <= '0;
      rej_q <= 1'b0;
      valid_q <= '0;
      st_q <= ASP_IDLE;
      seg_q <= '0;
      addr_q <= '0;
      first_q <= '0;
      last_q <= '0;
      ext_sel_q <= '0;
      ext_vld_prev_q <= 1'b0;
      rd_q <= 1'b0;
      maddr_q <= '0;
      dac_q <= '0;
      dac_vld_q <= 1'b0;
    end else if (CLK_EN_IN) begin
      wait_q <= wait_d;
      rdata_q <= rdata_d;
      ctrl_q <= ctrl_d;
      active_q <= active_d;
      tidx_q <= tidx_d;
      tstart_q <= tstart_d;
      rej_q <= rej_d;
      valid_q <= valid_d;
      st_q <= st_d;
      seg_q <= seg_d;
      addr_q <= addr_d;
      first_q <= first_d;
      last_q <= last_d;
      ext_sel_q <= ext_sel_d;
      ext_vld_prev_q <= ext_s[`ASP_EXT_W];
      rd_q <= rd_d;
      maddr_q <= maddr_d;
      dac_q <= dac_d;
      dac_vld_q <= dac_vld_d;
    end
  end

  assign AVS_READDATA_OUT = rdata_q;
  assign AVS_WAITREQUEST_OUT = wait_q;
  assign MEM_ADDR_OUT = maddr_q;
  assign MEM_RD_OUT = rd_q;
  assign DAC_DATA_OUT = dac_q;
  assign DAC_VALID_OUT = dac_vld_q;

endmodule : asp_playback

`default_nettype wire

// ### include/asp_defines.svh
/*
  asp_defines.svh: offsets, field positions, reset values and sizes of the
  segment playback engine.
  Assumes inclusion by bare name from the package and the design files.
*/
`ifndef ASP_DEFINES_SVH
`define ASP_DEFINES_SVH

`define ASP_BUS_AW 5
`define ASP_OFS_CTRL 5'h00
`define ASP_OFS_ACTIVE 5'h04
`define ASP_OFS_TIDX 5'h08
`define ASP_OFS_TSTART 5'h0c
`define ASP_OFS_TLEN 5'h10
`define ASP_OFS_STATUS 5'h14
`define ASP_OFS_ADDR 5'h18

`define ASP_CTRL_EN 0
`define ASP_CTRL_SRC 1
`define ASP_CTRL_IMM 2
`define ASP_CTRL_DEL 3
`define ASP_CTRL_W 3
`define ASP_CTRL_RST 3'h0

`define ASP_ST_PLAY 0
`define ASP_ST_EMPTY 1
`define ASP_ST_REJ 2
`define ASP_ST_PEND 3
`define ASP_ST_SEG_LSB 16

`define ASP_SAMPLE_W 12
`define ASP_MEM_DEPTH_BASE 32000000
`define ASP_MEM_DEPTH_OPT 64000000
`define ASP_ADDR_W 26
`define ASP_SEG_COUNT 32768
`define ASP_MIN_SEG_LEN 384
`define ASP_SEG_GRAN 32
`define ASP_EXT_W 8

`endif

// ### include/asp_pkg.sv
/*
  asp_pkg: types shared by the segment playback engine.
  Assumes asp_defines.svh is on the include path.
*/
`default_nettype none
`include "asp_defines.svh"

package asp_pkg;

  // gray along idle -> run -> empty
  typedef enum logic [1:0] {
    ASP_IDLE = 2'h0,
    ASP_RUN = 2'h1,
    ASP_EMPTY = 2'h3
  } asp_state_type;

endpackage : asp_pkg

`default_nettype wire

// ### hdl/asp_sync3.sv
/*
  asp_sync3: three-stage synchroniser for a group of pin inputs.
  Assumes asynchronous pins; a bit changes once stages two and three agree.
*/
`timescale 1ns/1ps
`default_nettype none

module asp_sync3 #(
  parameter int W = 1
) (
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire logic ce_in,
  input wire logic [W-1:0] pin_in,
  output logic [W-1:0] stable_out
);

  logic [W-1:0] s1_q, s2_q, s3_q, stable_q;
  logic [W-1:0] stable_d;

  always_comb begin
    stable_d = stable_q;
    for (int i = 0; i < W; i++) begin
      if (s2_q[i] == s3_q[i]) begin
        stable_d[i] = s3_q[i];
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
      stable_q <= '0;
    end else if (ce_in) begin
      s1_q <= pin_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
      stable_q <= stable_d;
    end
  end

  assign stable_out = stable_q;

endmodule : asp_sync3

`default_nettype wire

// ### dv/asp_mem_model.sv
/*
  asp_mem_model: working memory beside the playback engine; the word for the
  registered fetch address stands in the fetch cycle itself.
  Assumes the engine's fetch strobe and address; word = address ^ 12'ha5c.
*/
`timescale 1ns/1ps
`default_nettype none

module asp_mem_model (
  input wire logic clk_in,
  input wire logic ce_in,
  input wire logic rd_in,
  input wire logic [25:0] addr_in,
  output logic [11:0] data_out
);
  logic [11:0] junk_q = 12'h000;
  // junk moves outside read cycles so a sample taken at the wrong time shows
  always @(posedge clk_in) begin
    if (ce_in)
      junk_q <= ~junk_q;
  end
  assign data_out = rd_in ? (addr_in[11:0] ^ 12'ha5c) : junk_q;
endmodule : asp_mem_model

`default_nettype wire

// ### dv/asp_playback_chk.sv
/*
  asp_playback_chk: port-level assertions on the playback engine.
  Assumes a single clock domain and the bind at the foot of this file.
*/
`timescale 1ns/1ps
`default_nettype none

module asp_playback_chk #(
  parameter int MEM_DEPTH = 32000000,
  parameter int AW = 26
) (
  input wire logic CLK_IN,
  input wire logic RESET_N_IN,
  input wire logic CLK_EN_IN,
  input wire logic AVS_READ_IN,
  input wire logic AVS_WRITE_IN,
  input wire logic [31:0] AVS_READDATA_OUT,
  input wire logic AVS_WAITREQUEST_OUT,
  input wire logic [AW-1:0] MEM_ADDR_OUT,
  input wire logic MEM_RD_OUT,
  input wire logic [11:0] DAC_DATA_OUT,
  input wire logic DAC_VALID_OUT
);
  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (!RESET_N_IN);
  sequence fetch_s;
    MEM_RD_OUT && CLK_EN_IN ##1 DAC_VALID_OUT;
  endsequence
  chk_bus_answer: assert property ((AVS_READ_IN || AVS_WRITE_IN) && AVS_WAITREQUEST_OUT && CLK_EN_IN
    |=> !AVS_WAITREQUEST_OUT) else $error("request not answered");
  chk_bus_single: assert property (!AVS_WAITREQUEST_OUT && CLK_EN_IN |=> AVS_WAITREQUEST_OUT)
    else $error("waitrequest low too long");
  chk_bus_cause: assert property ($fell(AVS_WAITREQUEST_OUT) |-> $past(AVS_READ_IN || AVS_WRITE_IN))
    else $error("answer without request");
  chk_fetch_valid: assert property (MEM_RD_OUT && CLK_EN_IN |-> fetch_s)
    else $error("fetch not sent out");
  chk_valid_cause: assert property ($past(CLK_EN_IN) |-> DAC_VALID_OUT == $past(MEM_RD_OUT))
    else $error("sample without fetch");
  chk_dac_hold: assert property (!DAC_VALID_OUT |-> $stable(DAC_DATA_OUT))
    else $error("idle output moved");
  chk_addr_range: assert property (MEM_RD_OUT |-> int'(MEM_ADDR_OUT) < MEM_DEPTH)
    else $error("fetch past memory end");
  chk_reset_quiet: assert property (disable iff (1'b0) !RESET_N_IN && CLK_EN_IN
    |=> AVS_WAITREQUEST_OUT && !MEM_RD_OUT && !DAC_VALID_OUT && AVS_READDATA_OUT == 32'h0)
    else $error("reset values wrong");
endmodule : asp_playback_chk

bind asp_playback asp_playback_chk #(.MEM_DEPTH(MEM_DEPTH), .AW(AW)) chk_u (
  .CLK_IN(CLK_IN), .RESET_N_IN(RESET_N_IN), .CLK_EN_IN(CLK_EN_IN),
  .AVS_READ_IN(AVS_READ_IN), .AVS_WRITE_IN(AVS_WRITE_IN),
  .AVS_READDATA_OUT(AVS_READDATA_OUT), .AVS_WAITREQUEST_OUT(AVS_WAITREQUEST_OUT),
  .MEM_ADDR_OUT(MEM_ADDR_OUT), .MEM_RD_OUT(MEM_RD_OUT),
  .DAC_DATA_OUT(DAC_DATA_OUT), .DAC_VALID_OUT(DAC_VALID_OUT));

`default_nettype wire

// ### dv/test_arb_segment_playback.sv
/*
  test_arb_segment_playback: self-checking bench of the playback engine.
  Assumes asp_mem_model as memory and the checker bound to the engine.
*/
`timescale 1ns/1ps
`default_nettype none
`include "asp_defines.svh"

module test_arb_segment_playback;
  logic clk = 1'b0, rst_n = 1'b0, ce = 1'b1, rd = 1'b0, wr = 1'b0, ext_vld = 1'b0;
  logic [4:0] addr = 5'h00;
  logic [31:0] wdata = 32'h0, rdata, q;
  logic [7:0] ext_seg = 8'h00;
  logic waitreq, mem_rd, dac_vld;
  logic [25:0] mem_addr;
  logic [11:0] mem_data, dac_data;
  logic [15:0] lfsr = 16'hf118;
  int failures = 0, compares = 0, cycles = 0;

  initial forever #12.5 clk = ~clk;

  asp_playback #(.MEM_DEPTH(4096), .SEG_COUNT(256)) dut_u (
    .CLK_IN(clk), .RESET_N_IN(rst_n), .CLK_EN_IN(ce), .AVS_ADDRESS_IN(addr),
    .AVS_READ_IN(rd), .AVS_WRITE_IN(wr), .AVS_WRITEDATA_IN(wdata), .AVS_BYTEENABLE_IN(4'hf),
    .AVS_READDATA_OUT(rdata), .AVS_WAITREQUEST_OUT(waitreq), .EXT_SEG_IN(ext_seg),
    .EXT_VALID_IN(ext_vld), .MEM_ADDR_OUT(mem_addr), .MEM_RD_OUT(mem_rd),
    .MEM_DATA_IN(mem_data), .DAC_DATA_OUT(dac_data), .DAC_VALID_OUT(dac_vld));

  asp_mem_model mem_u (.clk_in(clk), .ce_in(ce), .rd_in(mem_rd), .addr_in(mem_addr), .data_out(mem_data));

  function automatic logic [15:0] lfsr_next(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction : lfsr_next

  function automatic int nxt(input int p, input int s, input int l);
    return (p == s + l - 1) ? s : p + 1;
  endfunction : nxt

  task automatic results();
    if (failures == 0 && compares > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : results

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask : check

  // one access; an idle edge after it keeps strobes from being set twice at once
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    int n;
    n = 0;
    wr <= w;
    rd <= !w;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    while (waitreq !== 1'b0 && n < 50) begin
      @(posedge clk);
      n++;
    end
    q = rdata;
    check(32'(n < 50), 32'h1);
    wr <= 1'b0;
    rd <= 1'b0;
    @(posedge clk);
  endtask : bus

  task automatic entry(input int idx, input int st, input int len);
    bus(1'b1, `ASP_OFS_TIDX, 32'(idx));
    bus(1'b1, `ASP_OFS_TSTART, 32'(st));
    bus(1'b1, `ASP_OFS_TLEN, 32'(len));
  endtask : entry

  task automatic quiet(input int n);
    repeat (n) begin
      @(posedge clk);
      check({dac_vld, mem_rd}, 32'h0);
    end
  endtask : quiet

  // walks the output stream: old segment, at most one switch, then new segment
  task automatic follow(input int os, ol, ns, nl, input bit imm, input int n);
    int prev, a, k, sw, got;
    prev = -1;
    sw = 0;
    got = 0;
    for (k = 1; k <= n; k++) begin
      @(posedge clk);
      if (dac_vld === 1'b1) begin
        a = int'(dac_data ^ 12'ha5c);
        got++;
        if (sw == 0 && prev >= 0 && a != nxt(prev, os, ol)) begin
          sw = k;
          check(a, ns);
          if (!imm)
            check(prev, os + ol - 1);
          else
            check(32'(k < 12), 32'h1);
        end else if (prev >= 0)
          check(a, sw ? nxt(prev, ns, nl) : nxt(prev, os, ol));
        prev = a;
      end
    end
    check(32'(got > n / 2), 32'h1);
    if (ns != os)
      check(32'(sw != 0), 32'h1);
  endtask : follow

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      failures++;
      results();
    end
  end

  initial begin
    int n, len5, st5;
    int bad[3];
    bad = '{383, 400, 608};
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    bus(1'b0, `ASP_OFS_CTRL, 32'h0);
    check(q, 32'h0);
    bus(1'b0, 5'h1c, 32'h0);
    check(q, 32'h0);
    lfsr = lfsr_next(lfsr);
    len5 = 384 + 32 * lfsr[2:0];
    st5 = 2048 + 32 * lfsr[6:3];
    entry(0, 0, 384);
    entry(1, 1024, 416);
    entry(5, st5, len5);
    bus(1'b0, `ASP_OFS_STATUS, 32'h0);
    check(q[2], 32'h0);
    foreach (bad[i]) begin
      entry(2, 3500, bad[i]);
      bus(1'b0, `ASP_OFS_STATUS, 32'h0);
      check(q[2], 32'h1);
      bus(1'b1, `ASP_OFS_STATUS, 32'h4);
    end
    bus(1'b1, `ASP_OFS_ACTIVE, 32'h1);
    bus(1'b1, `ASP_OFS_CTRL, 32'h1);
    follow(1024, 416, 1024, 416, 1'b0, 900);
    ce <= 1'b0;
    @(posedge clk);
    q = {8'h00, dac_data, mem_addr[11:0]};
    repeat (8) begin
      @(posedge clk);
      check({8'h00, dac_data, mem_addr[11:0]}, q);
      check({dac_vld, mem_rd}, 32'h3);
    end
    ce <= 1'b1;
    bus(1'b1, `ASP_OFS_ACTIVE, 32'h0);
    follow(1024, 416, 0, 384, 1'b0, 900);
    bus(1'b1, `ASP_OFS_CTRL, 32'h5);
    bus(1'b1, `ASP_OFS_ACTIVE, 32'h5);
    follow(0, 384, st5, len5, 1'b1, 300);
    bus(1'b1, `ASP_OFS_CTRL, 32'h1);
    bus(1'b1, `ASP_OFS_ACTIVE, 32'h7);
    n = 0;
    while (dac_vld !== 1'b0 && n++ < 800) @(posedge clk);
    quiet(60);
    bus(1'b0, `ASP_OFS_STATUS, 32'h0);
    check(q[1], 32'h1);
    bus(1'b1, `ASP_OFS_ACTIVE, 32'h1);
    follow(1024, 416, 1024, 416, 1'b0, 300);
    bus(1'b1, `ASP_OFS_CTRL, 32'h9);
    // fetches already in flight still reach the converter
    repeat (2) @(posedge clk);
    quiet(60);
    entry(1, 1024, 416);
    follow(1024, 416, 1024, 416, 1'b0, 300);
    entry(0, 0, 384);
    entry(5, st5, len5);
    bus(1'b1, `ASP_OFS_CTRL, 32'h3);
    follow(1024, 416, 0, 384, 1'b0, 900);
    ext_seg <= 8'h05;
    repeat (6) @(posedge clk);
    ext_vld <= 1'b1;
    repeat (8) @(posedge clk);
    ext_vld <= 1'b0;
    follow(0, 384, st5, len5, 1'b0, 900);
    ext_seg <= 8'h01;
    follow(st5, len5, st5, len5, 1'b0, 800);
    results();
  end
endmodule : test_arb_segment_playback

`default_nettype wire
